// File: common/uii_pkg.sv
// Purpose: Shared constants and carriers for the interrupt identification block.
// Assumes: Byte-wide I/O port access with three address bits.
// Notes: Offsets are relative to the serial port base address.
package uii_pkg;
    // Port offsets.
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER = 3'h1;
    localparam logic [2:0] OFS_IDENT = 3'h2;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    // Reset values.
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] DIVH_RST = 8'h00;
    localparam logic [7:0] IDENT_RST = 8'h01;
    // Enable register bit positions.
    localparam int IE_RDA = 0;
    localparam int IE_THRE = 1;
    localparam int IE_RLS = 2;
    localparam int IE_MS = 3;
    localparam logic [3:0] IE_MASK = 4'hF;
    // Identification register field positions.
    localparam int ID_PEND_N = 0;
    localparam int ID_TYPE_LO = 1;
    localparam int ID_TOUT = 3;
    localparam int ID_FIFO_LO = 6;
    // Pending type codes.
    localparam logic [1:0] PT_MS = 2'b00;
    localparam logic [1:0] PT_THRE = 2'b01;
    localparam logic [1:0] PT_RDA = 2'b10;
    localparam logic [1:0] PT_RLS = 2'b11;
    // Character times of silence before a receive timeout.
    localparam logic [2:0] TOUT_CHARS = 3'h4;
    // Host I/O request, all fields on core_clk.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uii_io_t;
    // Events and levels from the rest of the port.
    typedef struct packed {
        logic line_err;
        logic rx_ready;
        logic thr_empty;
        logic modem_chg;
        logic rx_push;
        logic rx_nonempty;
        logic char_tick;
    } uii_evt_t;
endpackage

// File: hw/uii_timeout.sv
// Purpose: Receive character timeout detector.
// Assumes: char_tick pulses once per character time on core_clk.
// Notes: Works only while FIFO mode is on.
`timescale 1ns/10ps
module uii_timeout (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic fifo_mode,
    input wire logic rx_push,
    input wire logic rx_pop,
    input wire logic rx_nonempty,
    input wire logic char_tick,
    output logic tout_flag
);
    import uii_pkg::*;

    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic next_tout_flag;
    logic restart;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // Restart on any FIFO traffic and idle while empty or out of FIFO mode.
    always_comb begin
        restart = rx_push | rx_pop | ~rx_nonempty | ~fifo_mode;
        hit = char_tick & ~restart & (cnt == TOUT_CHARS - 3'h1);
        next_cnt = cnt;
        if (restart) begin
            next_cnt = 3'h0;
        end else if (char_tick && cnt != TOUT_CHARS) begin
            next_cnt = cnt + 3'h1;
        end
        next_tout_flag = tout_flag;
        if (rx_pop || !fifo_mode) begin
            next_tout_flag = 1'b0;
        end
        if (hit) begin
            next_tout_flag = 1'b1;
        end
    end

    // Counter and flag registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 3'h0;
            tout_flag <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tout_flag <= next_tout_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag rises only after four silent character times with data held.
    tout_after_four_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(tout_flag) |-> $past(char_tick) && $past(cnt) == 3'h3)
        else $error("timeout flag set before four character times");
    // Traffic restarts the count.
    traffic_restart_a: assert property (@(posedge core_clk) disable iff (rst)
        (rx_push || rx_pop || !rx_nonempty) |=> cnt == 3'h0)
        else $error("timeout counter not restarted by traffic");
endmodule

// File: hw/uii_top.sv
// Purpose: Interrupt identification, enable and divisor high byte of a serial port.
// Assumes: Host I/O strobes and status events come from logic on core_clk.
// Notes: A read holds io.rd high for the whole access; read data stands until it ends.
//
// How it works
// - Line status outranks received data, which outranks transmit empty, then modem status.
// - A read of the identification register freezes and presents the top pending source.
// - New events are still recorded during that read but the presented value stays put.
// - Bits 7 and 6 read as one while the FIFOs are enabled.
// - Bits 5 and 4 always read as zero.
// - Bit 3 is the timeout flag, set with bit 2 in FIFO mode and zero otherwise.
// - The type field codes modem 00, transmit empty 01, received data 10, line status 11.
// - Bit 0 is low when something is pending, so an idle read gives 01h with the FIFOs off and C1h with them on.
// - Line errors raise the line status source; reading the line status register clears it.
// - Received data is pending while data or the trigger level is present and drops with it.
// - In FIFO mode a timeout is flagged after four quiet character times with data held; a data read clears it.
// - Transmit empty clears on an identification read reporting it, or on a data write.
// - Modem line changes raise the modem source; reading the modem status register clears it.
// - The divisor high byte is a full read/write byte.
// - Offset one reaches the divisor high byte with the latch select set, else the enables.
// - A disabled source is never reported though its flags keep working.
`timescale 1ns/10ps
module uii_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire uii_pkg::uii_io_t io,
    input wire uii_pkg::uii_evt_t evt,
    input wire logic fifos_enabled_flags,
    input wire logic divisor_latch_select,
    output logic [7:0] io_rdata,
    output logic [7:0] divisor_high_byte,
    output logic [3:0] irq_enable,
    output logic irq_pending,
    output logic rx_pop
);
    import uii_pkg::*;

    logic rd_q;
    logic rd_start;
    logic rd_end;
    logic rls_flag;
    logic thre_flag;
    logic ms_flag;
    logic tout_flag;
    logic ident_read;
    logic [7:0] ident_live;
    logic [7:0] ident_hold;
    logic [7:0] next_io_rdata;
    logic [7:0] next_divisor_high_byte;
    logic [3:0] next_irq_enable;
    logic next_irq_pending;
    logic next_rx_pop;
    logic next_rls_flag;
    logic next_thre_flag;
    logic next_ms_flag;
    logic next_ident_read;
    logic [7:0] next_ident_hold;
    logic [3:0] pend;

    ////////////////////////////////////////////////////////////////////////
    // Build the identification byte from the enabled pending sources.
    function automatic logic [7:0] ident_code(input logic [3:0] p, input logic tout,
                                              input logic fifo_on);
        logic [7:0] v;
        v = IDENT_RST;
        if (p[IE_RLS]) begin
            v[ID_TOUT:ID_TYPE_LO] = {1'b0, PT_RLS};
        end else if (p[IE_RDA]) begin
            v[ID_TOUT:ID_TYPE_LO] = {tout & fifo_on, PT_RDA};
        end else if (p[IE_THRE]) begin
            v[ID_TOUT:ID_TYPE_LO] = {1'b0, PT_THRE};
        end else begin
            v[ID_TOUT:ID_TYPE_LO] = {1'b0, PT_MS};
        end
        v[ID_PEND_N] = ~(|p);
        v[ID_FIFO_LO+1:ID_FIFO_LO] = {2{fifo_on}};
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Access edges and the live identification value.
    always_comb begin
        rd_start = io.rd & ~rd_q;
        rd_end = rd_q & ~io.rd;
        pend[IE_RLS] = rls_flag & irq_enable[IE_RLS];
        pend[IE_RDA] = (evt.rx_ready | tout_flag) & irq_enable[IE_RDA];
        pend[IE_THRE] = thre_flag & irq_enable[IE_THRE];
        pend[IE_MS] = ms_flag & irq_enable[IE_MS];
        ident_live = ident_code(pend, tout_flag, fifos_enabled_flags);
    end

    // Receive timeout detector.
    uii_timeout u_tout (
        .core_clk(core_clk),
        .rst(rst),
        .fifo_mode(fifos_enabled_flags),
        .rx_push(evt.rx_push),
        .rx_pop(rx_pop),
        .rx_nonempty(evt.rx_nonempty),
        .char_tick(evt.char_tick),
        .tout_flag(tout_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sticky source flags; a set in the clearing cycle wins.
    always_comb begin
        next_rls_flag = rls_flag;
        next_thre_flag = thre_flag;
        next_ms_flag = ms_flag;
        if (rd_start && io.addr == OFS_LSR) begin
            next_rls_flag = 1'b0;
        end
        if (rd_start && io.addr == OFS_MSR) begin
            next_ms_flag = 1'b0;
        end
        if (io.wr && io.addr == OFS_DATA && !divisor_latch_select) begin
            next_thre_flag = 1'b0;
        end
        if (rd_end && ident_read && ident_hold[ID_PEND_N] == 1'b0
            && ident_hold[ID_TOUT:ID_TYPE_LO] == {1'b0, PT_THRE}) begin
            next_thre_flag = 1'b0;
        end
        if (evt.line_err) begin
            next_rls_flag = 1'b1;
        end
        if (evt.thr_empty) begin
            next_thre_flag = 1'b1;
        end
        if (evt.modem_chg) begin
            next_ms_flag = 1'b1;
        end
    end

    // Source flag registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rls_flag <= 1'b0;
            thre_flag <= 1'b0;
            ms_flag <= 1'b0;
        end else begin
            rls_flag <= next_rls_flag;
            thre_flag <= next_thre_flag;
            ms_flag <= next_ms_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host access: writes, read data and the frozen identification value.
    always_comb begin
        next_divisor_high_byte = divisor_high_byte;
        next_irq_enable = irq_enable;
        next_io_rdata = io_rdata;
        next_ident_read = ident_read;
        next_ident_hold = ident_hold;
        next_rx_pop = rd_start && io.addr == OFS_DATA && !divisor_latch_select;
        next_irq_pending = ~ident_live[ID_PEND_N];
        if (io.wr && io.addr == OFS_IER) begin
            if (divisor_latch_select) begin
                next_divisor_high_byte = io.wdata;
            end else begin
                next_irq_enable = io.wdata[3:0] & IE_MASK;
            end
        end
        if (rd_start) begin
            next_ident_read = io.addr == OFS_IDENT;
            next_ident_hold = ident_live;
            case (io.addr)
                OFS_IER: begin
                    next_io_rdata = divisor_latch_select ? divisor_high_byte
                                                         : {4'h0, irq_enable};
                end
                OFS_IDENT: begin
                    next_io_rdata = ident_live;
                end
                default: begin
                    next_io_rdata = 8'h00;
                end
            endcase
        end else if (rd_end) begin
            next_ident_read = 1'b0;
        end
    end

    // Host access registers; read data stands while io.rd stays high.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_q <= 1'b0;
            divisor_high_byte <= DIVH_RST;
            irq_enable <= IER_RST[3:0];
            io_rdata <= 8'h00;
            ident_read <= 1'b0;
            ident_hold <= IDENT_RST;
            rx_pop <= 1'b0;
            irq_pending <= 1'b0;
        end else begin
            rd_q <= io.rd;
            divisor_high_byte <= next_divisor_high_byte;
            irq_enable <= next_irq_enable;
            io_rdata <= next_io_rdata;
            ident_read <= next_ident_read;
            ident_hold <= next_ident_hold;
            rx_pop <= next_rx_pop;
            irq_pending <= next_irq_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the presented identification value and source flags.
    line_first_a: assert property (@(posedge core_clk) disable iff (rst)
        pend[IE_RLS] |-> ident_live[ID_TOUT:ID_TYPE_LO] == {1'b0, PT_RLS})
        else $error("line status not ranked first");
    ident_frozen_a: assert property (@(posedge core_clk) disable iff (rst)
        (ident_read && io.rd && rd_q) |=> $stable(io_rdata))
        else $error("identification value changed during a read");
    ident_snap_a: assert property (@(posedge core_clk) disable iff (rst)
        (io.rd && !rd_q && io.addr == OFS_IDENT) |=> io_rdata == $past(ident_live))
        else $error("identification read did not present the live value");
    fifo_bits_a: assert property (@(posedge core_clk) disable iff (rst)
        ident_live[7:6] == {2{fifos_enabled_flags}} && ident_live[5:4] == 2'b00)
        else $error("top or reserved identification bits wrong");
    idle_code_a: assert property (@(posedge core_clk) disable iff (rst)
        (pend == 4'h0 && !fifos_enabled_flags) |-> ident_live == IDENT_RST)
        else $error("idle identification value is not 01h");
    tout_bit_a: assert property (@(posedge core_clk) disable iff (rst)
        ident_live[ID_TOUT] |-> fifos_enabled_flags && ident_live[2])
        else $error("timeout bit without FIFO mode or bit 2");
    lsr_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (io.rd && !rd_q && io.addr == OFS_LSR && !evt.line_err) |=> !rls_flag)
        else $error("line status source not cleared by its read");
    msr_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        (io.rd && !rd_q && io.addr == OFS_MSR && !evt.modem_chg) |=> !ms_flag)
        else $error("modem source not cleared by its read");
    thr_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (io.wr && io.addr == OFS_DATA && !divisor_latch_select && !evt.thr_empty)
        |=> !thre_flag)
        else $error("transmit empty not cleared by a data write");
    masked_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        (irq_enable == 4'h0) |-> ident_live[ID_PEND_N])
        else $error("disabled source reported as pending");
    divh_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (io.wr && io.addr == OFS_IER && divisor_latch_select)
        |=> divisor_high_byte == $past(io.wdata) && $stable(irq_enable))
        else $error("divisor high byte write misrouted");
endmodule

// File: testbench/uii_host.sv
// Purpose: Host processor model that issues byte reads and writes to the port.
// Assumes: Requests change just after a rising edge of core_clk.
// Notes: Released address and data lines carry inverted values, not the last ones.
`timescale 1ns/10ps
module uii_host (
    input wire logic core_clk,
    input wire logic [7:0] io_rdata,
    output uii_pkg::uii_io_t io,
    output logic divisor_latch_select
);
    import uii_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // The bus is idle at time zero.
    initial begin
        io = '0;
        divisor_latch_select = 1'b0;
    end

    // Sets the latch select before any access to offset one.
    task automatic sel(input logic s);
        @(posedge core_clk);
        divisor_latch_select <= s;
    endtask

    // Write strobe stands for one cycle; data is scrambled once released.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        io.wr <= 1'b1;
        io.addr <= a;
        io.wdata <= d;
        @(posedge core_clk);
        io.wr <= 1'b0;
        io.addr <= ~a;
        io.wdata <= ~d;
    endtask

    // Read is held two cycles past the answer, then dropped for one cycle.
    // The long hold lets a late event reach the flags after the value has frozen, before it is taken.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk);
        io.rd <= 1'b1;
        io.addr <= a;
        @(posedge core_clk);
        @(posedge core_clk);
        @(posedge core_clk);
        d = io_rdata;
        io.rd <= 1'b0;
        io.addr <= ~a;
        @(posedge core_clk);
    endtask
endmodule

// File: testbench/uart_interrupt_identification_tb.sv
// Purpose: Self-checking bench for the interrupt identification block.
// Assumes: The host model drives the I/O request; the bench drives the events.
// Notes: A reference model of the source flags predicts every identification read.
`timescale 1ns/10ps
module uart_interrupt_identification_tb;
    import uii_pkg::*;
    localparam logic [6:0] P_LE = 7'h40;
    localparam logic [6:0] P_TE = 7'h10;
    localparam logic [6:0] P_MC = 7'h08;
    localparam logic [6:0] P_PU = 7'h04;
    localparam logic [6:0] P_TK = 7'h01;
    logic core_clk;
    logic rst;
    uii_io_t io;
    uii_evt_t evt;
    logic fifos_enabled_flags;
    logic divisor_latch_select;
    logic [7:0] io_rdata;
    logic [7:0] divisor_high_byte;
    logic [3:0] irq_enable;
    logic irq_pending;
    logic rx_pop;
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] divh = 8'h00;
    logic [3:0] ier = 4'h0;
    int bad_count = 0;
    int compares = 0;
    int seed;
    int pops = 0;
    int npop = 0;
    int rls = 0, thre = 0, ms = 0, tout = 0, cnt = 0, rxr = 0, ne = 0, fifo = 0;

    uii_top dut (.core_clk(core_clk), .rst(rst), .io(io), .evt(evt),
        .fifos_enabled_flags(fifos_enabled_flags), .divisor_latch_select(divisor_latch_select),
        .io_rdata(io_rdata), .divisor_high_byte(divisor_high_byte), .irq_enable(irq_enable),
        .irq_pending(irq_pending), .rx_pop(rx_pop));
    uii_host host (.core_clk(core_clk), .io_rdata(io_rdata), .io(io),
        .divisor_latch_select(divisor_latch_select));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 250 MHz and a watchdog that cuts a hang short.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        stop_test();
    end

    // Counts receive buffer pops; a strobe held too long counts twice.
    always @(posedge core_clk) begin
        if (rx_pop === 1'b1) pops++;
    end

    // Predicts the identification byte from the model flags.
    function automatic logic [7:0] exp_id();
        logic [7:0] x;
        x = fifo ? 8'hC0 : 8'h00;
        if (ier[IE_RLS] && rls) x[3:0] = 4'h6;
        else if (ier[IE_RDA] && tout) x[3:0] = 4'hC;
        else if (ier[IE_RDA] && rxr) x[3:0] = 4'h4;
        else if (ier[IE_THRE] && thre) x[3:0] = 4'h2;
        else if (ier[IE_MS] && ms) x[3:0] = 4'h0;
        else x[3:0] = 4'h1;
        return x;
    endfunction

    // Compares and counts; reports a mismatch at once.
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Pulses event lines for one cycle and updates the model.
    task automatic pulse(input logic [6:0] m);
        @(posedge core_clk);
        evt <= uii_evt_t'(evt | m);
        @(posedge core_clk);
        evt <= uii_evt_t'(evt & ~m);
        if (m[6]) rls = 1;
        if (m[4]) thre = 1;
        if (m[3]) ms = 1;
        if (m[2]) cnt = 0;
        if (m[0] && fifo && ne) cnt++;
        if (cnt >= 4) tout = 1;
    endtask

    // Sets the receive level inputs.
    task automatic lvl(input logic r, input logic n);
        @(posedge core_clk);
        evt.rx_ready <= r;
        evt.rx_nonempty <= n;
        rxr = r;
        ne = n;
    endtask

    // Reads, compares and applies the read side effects to the model.
    task automatic rdm(input logic [2:0] a, input logic [7:0] x, input string n);
        logic [7:0] r;
        host.rd(a, r);
        check(n, r, x);
        if (a == OFS_LSR) rls = 0;
        if (a == OFS_MSR) ms = 0;
        if (a == OFS_DATA && !divisor_latch_select) begin
            cnt = 0;
            tout = 0;
            npop++;
        end
        if (a == OFS_IDENT && x[3:0] == 4'h2) thre = 0;
    endtask

    // Writes and applies the write side effects to the model.
    task automatic wrm(input logic [2:0] a, input logic [7:0] x);
        host.wr(a, x);
        if (a == OFS_IER && divisor_latch_select) divh = x;
        else if (a == OFS_IER) ier = x[3:0];
        if (a == OFS_DATA && !divisor_latch_select) thre = 0;
    endtask

    // Checks the pending output, then reads the identification byte.
    task automatic chk_id(input string n);
        logic [7:0] x;
        repeat (3) @(posedge core_clk);
        x = exp_id();
        check("pending", {7'h00, irq_pending}, {7'h00, ~x[0]});
        rdm(OFS_IDENT, x, n);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst = 1'b1;
        evt = '0;
        fifos_enabled_flags = 1'b0;
        seed = 97;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        chk_id("ident idle");
        @(posedge core_clk);
        fifos_enabled_flags <= 1'b1;
        fifo = 1;
        chk_id("ident fifo");
        rdm(OFS_IER, 8'h00, "enable rst");
        for (int i = 3; i < 8; i++) rdm(3'(i), 8'h00, "other offset");
        host.sel(1'b1);
        rdm(OFS_IER, 8'h00, "divisor rst");
        repeat (3) begin
            d = 8'($random(seed));
            wrm(OFS_IER, d);
            rdm(OFS_IER, divh, "divisor rd");
            check("divisor port", divisor_high_byte, divh);
        end
        host.sel(1'b0);
        wrm(OFS_IER, 8'($random(seed)));
        rdm(OFS_IER, {4'h0, ier}, "enable rd");
        check("divisor kept", divisor_high_byte, divh);
        check("enable port", {4'h0, irq_enable}, {4'h0, ier});
        wrm(OFS_IER, 8'h0F);
        pulse(P_MC);
        chk_id("modem");
        pulse(P_TE);
        chk_id("thre");
        pulse(P_TE);
        lvl(1'b1, 1'b0);
        chk_id("rda");
        pulse(P_LE);
        chk_id("rls");
        rdm(OFS_LSR, 8'h00, "lsr read");
        chk_id("after lsr");
        lvl(1'b0, 1'b0);
        chk_id("rda dropped");
        chk_id("thre cleared");
        rdm(OFS_MSR, 8'h00, "msr read");
        chk_id("all clear");
        pulse(P_MC);
        e = exp_id();
        fork
            host.rd(OFS_IDENT, v);
            begin
                repeat (1) @(posedge core_clk);
                evt.line_err <= 1'b1;
                @(posedge core_clk);
                evt.line_err <= 1'b0;
            end
        join
        check("frozen", v, e);
        rls = 1;
        chk_id("late rls");
        rdm(OFS_LSR, 8'h00, "lsr read");
        rdm(OFS_MSR, 8'h00, "msr read");
        pulse(P_LE | P_TE | P_MC);
        wrm(OFS_IER, 8'h00);
        chk_id("masked");
        wrm(OFS_IER, 8'h0F);
        chk_id("unmasked");
        rdm(OFS_LSR, 8'h00, "lsr read");
        rdm(OFS_MSR, 8'h00, "msr read");
        wrm(OFS_DATA, 8'($random(seed)));
        chk_id("thre by write");
        lvl(1'b0, 1'b1);
        repeat (3) pulse(P_TK);
        pulse(P_PU);
        repeat (3) pulse(P_TK);
        chk_id("no timeout");
        pulse(P_TK);
        chk_id("timeout");
        rdm(OFS_DATA, 8'h00, "data read");
        chk_id("popped");
        repeat (4) pulse(P_TK);
        chk_id("timeout again");
        @(posedge core_clk);
        fifos_enabled_flags <= 1'b0;
        fifo = 0;
        tout = 0;
        cnt = 0;
        chk_id("fifo off");
        check("pops", 8'(pops), 8'(npop));
        stop_test();
    end
endmodule
